//--- design/ubc_pkg.sv
/*
 ubc_pkg: register map, field layout, reset values and counts
 for the baud divisor and serial clock block.
 assumes a 32-bit apb slave with word-aligned registers.
*/
package ubc_pkg;
  localparam logic [7:0]  OFF_DIV_LOW   = 8'h00;
  localparam logic [7:0]  OFF_DIV_HIGH  = 8'h04;
  localparam logic [7:0]  OFF_FRAME_RD  = 8'h08;
  localparam logic [7:0]  OFF_SPEED     = 8'h0C;
  localparam logic [7:0]  OFF_STATUS    = 8'h10;

  localparam int          DIV_W         = 12;
  localparam int          SEL_POS       = 7;
  localparam int          SYNC_POS      = 6;
  localparam int          PAR_POS       = 4;
  localparam int          STOP_POS      = 3;
  localparam int          SIZE_POS      = 1;
  localparam int          POL_POS       = 0;
  localparam int          SPEED_POS     = 0;
  localparam int          OS_POS        = 12;

  localparam logic [7:0]  DIV_LOW_RST   = 8'h00;
  localparam logic [3:0]  DIV_HIGH_RST  = 4'h0;
  localparam logic [6:0]  FRAME_RST     = 7'h06;
  localparam logic        SPEED_RST     = 1'b0;

  localparam logic [3:0]  OS_NORMAL     = 4'hF;
  localparam logic [3:0]  OS_DOUBLE     = 4'h7;
endpackage

//--- design/ubc_prescaler.sv
/*
 ubc_prescaler: down-counter that gives one tick per divisor+1 cycles.
 assumes the divisor is stable except across a reload pulse.
*/
module ubc_prescaler
  import ubc_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             reload,
  output logic      [DIV_W-1:0] count,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic             tick_q;
  logic             tick_d;

  always_comb begin
    cnt_d  = cnt_q - 12'h001;
    tick_d = 1'b0;
    if (reload) begin
      cnt_d = divisor; // [R9]
    end else if (cnt_q == 12'h000) begin
      cnt_d  = divisor; // [R15]
      tick_d = 1'b1;    // [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign count = cnt_q;
  assign tick  = tick_q;
endmodule

//--- design/ubc_top.sv
/*
 ubc_top: apb register file for the baud divisor and frame control,
 prescaler, oversampling divider and synchronous serial clock.
 assumes pclk is the oscillator clock, a well-behaved apb master,
 and that the transmitter and receiver act on the strobes given here.
*/
// Design decisions made here: the register offsets and the APB interface to the registers.
// Notes on behaviour
// R1 - software keeps clock polarity at zero in asynchronous mode, where it has no effect.
// R2 - polarity 0 shifts transmit on the rising serial clock and samples on the falling one.
// R3 - the divisor high byte and the frame control register share one address.
// R4 - reading the divisor high byte returns zero in the register select bit.
// R5 - software writes the register select bit low to update the divisor high byte.
// R6 - the three reserved high byte bits read zero and software writes them zero.
// R7 - the baud divisor is twelve bits, four from the high byte and eight from the low.
// R8 - changing the divisor mid-frame is not guarded and may corrupt that frame.
// R9 - a divisor low byte write reloads the prescaler at once with the full divisor.
// R10 - divisor zero gives the fastest rate, one tick per oscillator cycle.
// R11 - divisor 11 normal or 23 double speed gives 9600 baud from 1.8432 MHz.
// R12 - the double speed bit lowers the oversampling from 16 to 8 in asynchronous mode.
// R13 - software writes the register select bit high to update frame control.
// R14 - the sync mode bit chooses asynchronous or synchronous operation with serial clock.
// R15 - the prescaler counts down and reloads on zero, ticking every divisor+1 cycles.
module ubc_top
  import ubc_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic      [DIV_W-1:0] baud_divisor,
  output logic                  sync_mode,
  output logic                  double_speed,
  output logic      [1:0]       parity_mode,
  output logic                  stop_bits,
  output logic      [1:0]       char_size,
  output logic                  baud_tick,
  output logic                  tx_strobe,
  output logic                  rx_strobe,
  output logic                  serial_clock_out,
  output logic                  serial_clock_oe
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  logic [7:0]       div_low_q;
  logic [7:0]       div_low_d;
  logic [3:0]       div_high_q;
  logic [3:0]       div_high_d;
  logic [6:0]       frame_q;
  logic [6:0]       frame_d;
  logic             speed_q;
  logic             speed_d;
  logic             reload_q;
  logic             reload_d;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic             ready_q;
  logic             ready_d;
  logic             err_q;
  logic             err_d;
  logic             wr_en;
  logic             mapped;
  logic [DIV_W-1:0] pre_count;
  logic             pre_tick;
  logic [3:0]       os_q;
  logic [3:0]       os_d;

  // bus side
  assign wr_en  = psel & penable & pready & pwrite;
  assign mapped = hit(paddr, OFF_DIV_LOW) | hit(paddr, OFF_DIV_HIGH)
                | hit(paddr, OFF_FRAME_RD) | hit(paddr, OFF_SPEED)
                | hit(paddr, OFF_STATUS);

  always_comb begin
    div_low_d  = div_low_q;
    div_high_d = div_high_q;
    frame_d    = frame_q;
    speed_d    = speed_q;
    reload_d   = 1'b0;
    if (wr_en && hit(paddr, OFF_DIV_LOW)) begin
      div_low_d = pwdata[7:0];
      reload_d  = 1'b1; // [R9]
    end
    if (wr_en && hit(paddr, OFF_DIV_HIGH)) begin
      if (pwdata[SEL_POS]) begin
        frame_d = pwdata[6:0]; // [R3] [R13]
      end else begin
        div_high_d = pwdata[3:0]; // [R3] [R5] [R6]
      end
    end
    if (wr_en && hit(paddr, OFF_SPEED)) begin
      speed_d = pwdata[SPEED_POS];
    end
  end

  // answer is prepared in the setup cycle so pready can come from a flop
  always_comb begin
    ready_d = psel & ~penable;
    err_d   = psel & ~penable & ~mapped;
    rdata_d = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (hit(paddr, OFF_DIV_LOW)) begin
        rdata_d[7:0] = div_low_q;
      end
      if (hit(paddr, OFF_DIV_HIGH)) begin
        rdata_d[7:0] = {4'h0, div_high_q}; // [R4] [R6]
      end
      if (hit(paddr, OFF_FRAME_RD)) begin
        rdata_d[7:0] = {1'b1, frame_q};
      end
      if (hit(paddr, OFF_SPEED)) begin
        rdata_d[SPEED_POS] = speed_q;
      end
      if (hit(paddr, OFF_STATUS)) begin
        rdata_d[DIV_W-1:0]    = pre_count;
        rdata_d[OS_POS+3:OS_POS] = os_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_low_q  <= DIV_LOW_RST;
      div_high_q <= DIV_HIGH_RST;
      frame_q    <= FRAME_RST;
      speed_q    <= SPEED_RST;
      reload_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      ready_q    <= 1'b0;
      err_q      <= 1'b0;
    end else begin
      div_low_q  <= div_low_d;
      div_high_q <= div_high_d;
      frame_q    <= frame_d;
      speed_q    <= speed_d;
      reload_q   <= reload_d;
      rdata_q    <= rdata_d;
      ready_q    <= ready_d;
      err_q      <= err_d;
    end
  end

  // baud generation
  logic       xck_q;
  logic       xck_d;
  logic       tx_q;
  logic       tx_d;
  logic       rx_q;
  logic       rx_d;
  logic       oe_q;
  logic       oe_d;
  logic [3:0] os_last;
  logic       sync_on;
  logic       pol;
  logic       rising;

  // divisor change is not held off until a frame ends [R8]
  ubc_prescaler u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor ({div_high_q, div_low_q}), // [R7]
    .reload  (reload_q),
    .count   (pre_count),
    .tick    (pre_tick)
  );

  assign sync_on = frame_q[SYNC_POS];
  assign pol     = frame_q[POL_POS] & sync_on; // [R1]
  assign os_last = speed_q ? OS_DOUBLE : OS_NORMAL; // [R12] [R11]
  assign rising  = ~xck_q;

  always_comb begin
    os_d  = os_q;
    xck_d = xck_q;
    tx_d  = 1'b0;
    rx_d  = 1'b0;
    oe_d  = sync_on; // [R14]
    if (!sync_on) begin
      xck_d = 1'b0;
      if (pre_tick) begin
        rx_d = 1'b1;
        if (os_q >= os_last) begin
          os_d = 4'h0;
          tx_d = 1'b1; // [R12]
        end else begin
          os_d = os_q + 4'h1;
        end
      end
    end else begin
      os_d = 4'h0;
      if (pre_tick) begin
        xck_d = ~xck_q; // [R14]
        tx_d  = rising ^ pol;  // [R2]
        rx_d  = ~(rising ^ pol); // [R2]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_q  <= 4'h0;
      xck_q <= 1'b0;
      tx_q  <= 1'b0;
      rx_q  <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      os_q  <= os_d;
      xck_q <= xck_d;
      tx_q  <= tx_d;
      rx_q  <= rx_d;
      oe_q  <= oe_d;
    end
  end

  assign prdata           = rdata_q;
  assign pready           = ready_q;
  assign pslverr          = err_q;
  assign baud_divisor     = {div_high_q, div_low_q}; // [R7]
  assign sync_mode        = frame_q[SYNC_POS];
  assign double_speed     = speed_q;
  assign parity_mode      = frame_q[PAR_POS+1:PAR_POS];
  assign stop_bits        = frame_q[STOP_POS];
  assign char_size        = frame_q[SIZE_POS+1:SIZE_POS];
  assign baud_tick        = pre_tick;
  assign tx_strobe        = tx_q;
  assign rx_strobe        = rx_q;
  assign serial_clock_out = xck_q;
  assign serial_clock_oe  = oe_q;
endmodule

//--- tb/ubc_props.sv
/*
 ubc_props: checker bound to ubc_top.
 assumes only the top module's ports are visible.
*/
module ubc_props
  import ubc_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic             sync_mode,
  input wire logic             baud_tick,
  input wire logic             tx_strobe,
  input wire logic             rx_strobe,
  input wire logic             serial_clock_out,
  input wire logic             serial_clock_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic        wr;
  logic        pol_q;
  logic [1:0]  quiet_q;
  logic [11:0] gap_q;
  assign wr = psel && penable && pready && pwrite;
  // spacing is trusted only three ticks after any write, past the reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_q   <= 1'b0;
      quiet_q <= 2'h0;
      gap_q   <= 12'h000;
    end else begin
      gap_q <= baud_tick ? 12'h000 : gap_q + 12'h001;
      if (wr && paddr == OFF_DIV_HIGH && pwdata[SEL_POS]) pol_q <= pwdata[POL_POS];
      if (wr) quiet_q <= 2'h0;
      else if (baud_tick && quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
    end
  end
  property p_hi_rd; pready && !pwrite && paddr == OFF_DIV_HIGH |-> prdata[31:4] == '0; endproperty
  a_hi_rd: assert property (p_hi_rd)
    else $error("high byte read shows select or reserved bits");
  property p_hi_wr; wr && paddr == OFF_DIV_HIGH && !pwdata[SEL_POS]
    |=> baud_divisor[11:8] == $past(pwdata[3:0]); endproperty
  a_hi_wr: assert property (p_hi_wr)
    else $error("high nibble not stored");
  property p_frm_wr; wr && paddr == OFF_DIV_HIGH && pwdata[SEL_POS] |=> $stable(baud_divisor); endproperty
  a_frm_wr: assert property (p_frm_wr)
    else $error("frame write changed divisor");
  property p_reload; wr && paddr == OFF_DIV_LOW && pwdata[7:0] == 8'h00
    && baud_divisor[11:8] == 4'h0 |-> ##[1:5] baud_tick; endproperty
  a_reload: assert property (p_reload)
    else $error("low write did not reload prescaler");
  property p_gap; baud_tick && quiet_q == 2'h3 |-> gap_q == baud_divisor; endproperty
  a_gap: assert property (p_gap)
    else $error("tick spacing wrong");
  property p_edge; sync_mode && $rose(serial_clock_out)
    |-> ##[0:1] (pol_q ? rx_strobe : tx_strobe); endproperty
  a_edge: assert property (p_edge)
    else $error("strobe on wrong clock edge");
  property p_oe; $rose(sync_mode) |-> ##[0:1] serial_clock_oe; endproperty
  a_oe: assert property (p_oe)
    else $error("serial clock not enabled");
  property p_idle; !sync_mode [*3] |-> !serial_clock_oe && !serial_clock_out; endproperty
  a_idle: assert property (p_idle)
    else $error("serial clock active in async mode");
endmodule

bind ubc_top ubc_props u_props (.*);

//--- tb/ubc_partner.sv
/*
 ubc_partner: far-side transceiver, counts serial clock rises.
 assumes the clock line carries edges only while enabled.
*/
module ubc_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic serial_clock,
  input  wire logic clock_oe,
  output int        rises
);
  logic last_q;
  // a released line gives no edges, so only enabled rises count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 1'b0;
      rises  <= 0;
    end else begin
      last_q <= serial_clock;
      if (clock_oe && serial_clock && !last_q) rises <= rises + 1;
    end
  end
endmodule

//--- tb/ubc_top_bench.sv
/*
 ubc_top_bench: apb tests of divisor, frame and serial clock.
 assumes zero-wait apb slave and the partner model.
*/
module ubc_top_bench
  import ubc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sync_mode, double_speed, stop_bits, baud_tick, tx_strobe, rx_strobe;
  logic serial_clock_out, serial_clock_oe, err;
  logic [1:0] parity_mode, char_size;
  logic [DIV_W-1:0] baud_divisor;
  int num_errors, compares, cyc, rises, n, r0;
  int dv[4] = '{0, 0, 11, 23};
  int ds[4] = '{0, 1, 0, 1};
  int tp[4] = '{16, 8, 192, 192};
  always #50 pclk = ~pclk;
  ubc_top u_ubc_top (.*);
  ubc_partner u_ubc_partner (.pclk(pclk), .presetn(presetn), .serial_clock(serial_clock_out),
    .clock_oe(serial_clock_oe), .rises(rises));
  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write land in the flops before any output is compared
    @(posedge pclk);
  endtask
  // cycles between two pulses of the tick (k=0) or the transmit strobe
  task automatic gap(input int k, output int g);
    g = 0;
    do @(posedge pclk); while ((k == 0 ? baud_tick : tx_strobe) !== 1'b1);
    do begin
      @(posedge pclk);
      g++;
    end while ((k == 0 ? baud_tick : tx_strobe) !== 1'b1);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, OFF_DIV_LOW, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, OFF_DIV_HIGH, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, OFF_FRAME_RD, 32'h0);
    chk(rd, 32'h86);
    xfer(1'b1, OFF_DIV_HIGH, 32'h0F);
    xfer(1'b1, OFF_DIV_LOW, 32'hAB);
    chk(32'(baud_divisor), 32'hFAB);
    xfer(1'b1, OFF_DIV_HIGH, 32'h96);
    chk(32'(baud_divisor), 32'hFAB);
    chk(32'(parity_mode), 32'h1);
    chk(32'(stop_bits), 32'h0);
    chk(32'(char_size), 32'h3);
    chk(32'(sync_mode), 32'h0);
    xfer(1'b0, OFF_DIV_HIGH, 32'h0);
    chk(rd, 32'h0F);
    xfer(1'b0, OFF_FRAME_RD, 32'h0);
    chk(rd, 32'h96);
    xfer(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    xfer(1'b1, OFF_DIV_HIGH, 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, OFF_SPEED, 32'(ds[i]));
      xfer(1'b1, OFF_DIV_LOW, 32'(dv[i]));
      chk(32'(double_speed), 32'(ds[i]));
      gap(0, n);
      gap(0, n);
      chk(n, dv[i] + 1);
      gap(1, n);
      gap(1, n);
      chk(n, tp[i]);
    end
    xfer(1'b1, OFF_DIV_LOW, 32'hFF);
    repeat (20) @(posedge pclk);
    xfer(1'b1, OFF_DIV_LOW, 32'h0);
    for (n = 0; baud_tick !== 1'b1 && n < 300; n++) @(posedge pclk);
    chk(32'(n < 6), 32'h1);
    xfer(1'b1, OFF_DIV_LOW, 32'h3);
    for (int p = 0; p < 2; p++) begin
      r0 = rises;
      xfer(1'b1, OFF_DIV_HIGH, 32'hC6 | 32'(p));
      gap(1, n);
      chk(32'(serial_clock_out), 32'(p == 0));
      chk(32'(rx_strobe), 32'h0);
      chk(32'(serial_clock_oe), 32'h1);
      chk(32'(rises > r0), 32'h1);
      xfer(1'b1, OFF_DIV_HIGH, 32'h86);
      repeat (4) @(posedge pclk);
      chk(32'(serial_clock_oe), 32'h0);
    end
    report_and_stop();
  end
endmodule
